// *** ims_pkg.sv ***
package ims_pkg;

   // Link count and register indices; the byte address is four times the index.
   localparam int NLINK = 4;
   localparam logic [5:0] IDX_SYNC_LIVE = 6'h18;
   localparam logic [5:0] IDX_SYNC_IE = 6'h19;
   localparam logic [5:0] IDX_SYNC_LS = 6'h1a;
   localparam logic [5:0] IDX_SKEW = 6'h1b;
   localparam logic [5:0] IDX_SKEW_IE = 6'h1c;
   localparam logic [5:0] IDX_SKEW_LS = 6'h1d;
   localparam logic [5:0] IDX_OOF_IE = 6'h1e;
   localparam logic [5:0] IDX_OOF_LS = 6'h1f;
   localparam logic [1:0] WORD_LSB = 2'h0;

   // Reset values and field positions.
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam int FAR_LSB = 4;
   localparam int LOCAL_LSB = 0;
   localparam int SKEW_ERR_BIT = 0;

   // Skew timing: one count of the skew value is 250 us.
   localparam int CLK_KHZ = 20000;
   localparam int SKEW_LSB_US = 250;
   localparam int TICK_CYC = SKEW_LSB_US * CLK_KHZ / 1000;
   localparam int SKEW_MAX_US = 64000;
   localparam int SKEW_LIMIT_US = 7750;
   localparam logic [7:0] SKEW_LIMIT_CNT = 8'(SKEW_LIMIT_US / SKEW_LSB_US);
   localparam logic [7:0] SKEW_FULL = 8'(SKEW_MAX_US / SKEW_LSB_US - 1);

   // Per-link events from the framing logic, all on ref_clk.
   typedef struct packed {
      logic [NLINK-1:0] far_rsync_cmd;
      logic [NLINK-1:0] far_oof;
      logic [NLINK-1:0] local_in_step;
      logic [NLINK-1:0] local_oof;
      logic [NLINK-1:0] frame_mark;
      logic [NLINK-1:0] participate;
   } ims_link_ev_t;

   // Interrupt enable registers.
   typedef struct packed {
      logic [7:0] sync_ie;
      logic [7:0] skew_ie;
      logic [7:0] oof_ie;
   } ims_ctrl_t;

   typedef enum {MS_IDLE, MS_RUN} ims_meas_t;

endpackage

// *** ims_sticky.sv ***
`timescale 1ns/1ns
module ims_sticky
   import ims_pkg::*;
#(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Events and clears
   input wire logic [W-1:0] set_lvl,
   input wire logic [W-1:0] clr_w1c,
   // Latched state
   output logic [W-1:0] latched
);

   logic [W-1:0] next_latched;

   always_comb begin
      next_latched = set_lvl | (latched & ~clr_w1c);
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         latched <= W'(RST_REG);
      end else begin
         latched <= next_latched;
      end
   end

   set_wins_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (set_lvl != '0) |=> ((latched & $past(set_lvl)) == $past(set_lvl)))
      else $error("Latched bit lost an event.");
   clr_keep_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      (clr_w1c == '0) |=> ((latched & $past(latched)) == $past(latched)))
      else $error("Latched bit dropped without a clear.");

endmodule // ims_sticky

// *** ims_skew_meter.sv ***
`timescale 1ns/1ns
module ims_skew_meter
   import ims_pkg::*;
#(
   parameter int TICK = TICK_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Link frame markers
   input wire logic [NLINK-1:0] frame_mark,
   input wire logic [NLINK-1:0] participate,
   // Result
   output logic [7:0] skew,
   output logic skew_valid
);

   localparam int TW = $clog2(TICK);

   ims_meas_t state;
   ims_meas_t next_state;
   logic [TW-1:0] tick;
   logic [TW-1:0] next_tick;
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic [NLINK-1:0] seen;
   logic [NLINK-1:0] next_seen;
   logic [7:0] next_skew;
   logic next_valid;
   logic [NLINK-1:0] hits;

   // The count starts at the first marker and stops once every bonded link has marked.
   always_comb begin
      hits = frame_mark & participate;
      next_state = state;
      next_tick = tick;
      next_cnt = cnt;
      next_seen = seen;
      next_skew = skew;
      next_valid = 1'b0;
      unique case (state)
         MS_IDLE: begin
            next_tick = '0;
            next_cnt = '0;
            next_seen = hits;
            if (hits != '0) begin
               if (hits == participate) begin
                  next_skew = '0;
                  next_valid = 1'b1;
               end else begin
                  next_state = MS_RUN;
               end
            end
         end
         MS_RUN: begin
            next_seen = seen | hits;
            if (tick == TW'(TICK - 1)) begin
               next_tick = '0;
               if (cnt != SKEW_FULL) begin
                  next_cnt = cnt + 8'h01;
               end
            end else begin
               next_tick = tick + TW'(1);
            end
            if (next_seen == participate || (cnt == SKEW_FULL && next_tick == '0)) begin
               next_skew = cnt;
               next_valid = 1'b1;
               next_state = MS_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state <= MS_IDLE;
         tick <= '0;
         cnt <= RST_REG;
         seen <= '0;
         skew <= RST_REG;
         skew_valid <= 1'b0;
      end else begin
         state <= next_state;
         tick <= next_tick;
         cnt <= next_cnt;
         seen <= next_seen;
         skew <= next_skew;
         skew_valid <= next_valid;
      end
   end

   valid_pulse_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      skew_valid |=> !skew_valid)
      else $error("Skew result held for more than one cycle.");
   tick_bound_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      tick <= TW'(TICK - 1))
      else $error("Skew tick counter overran.");

endmodule // ims_skew_meter

// *** ims_event_bank.sv ***
`timescale 1ns/1ns
module ims_event_bank
   import ims_pkg::*;
#(
   parameter int TICK = TICK_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Link events
   input wire ims_link_ev_t link_ev,
   // Status outputs
   output logic [NLINK-1:0] far_end_in_step,
   output logic bonding_irq_summary
);

   ims_ctrl_t ctrl;
   ims_ctrl_t next_ctrl;
   logic next_ack;
   logic [31:0] next_dat;
   logic [NLINK-1:0] next_far;
   logic next_irq;
   logic wr_cyc;
   logic [7:0] sync_ls;
   logic [7:0] oof_ls;
   logic [0:0] skew_ls;
   logic [7:0] clr_sync;
   logic [7:0] clr_oof;
   logic [0:0] clr_skew;
   logic [7:0] skew_val;
   logic skew_valid;
   logic [0:0] skew_err_set;
   logic [7:0] sync_live;
   logic [7:0] pend_sync;
   logic [7:0] pend_oof;
   logic pend_skew;
   logic pending;

   // Word-aligned hit on one register index.
   function automatic logic reg_hit(input logic [7:0] adr, input logic [5:0] idx);
      reg_hit = (adr[7:2] == idx) && (adr[1:0] == WORD_LSB);
   endfunction

   // Write strobe: taken on the edge where ack is high, low byte lane only.
   always_comb begin
      wr_cyc = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
   end

   // Far-end sync: set by a received sync command, dropped when the far end loses frame.
   always_comb begin
      next_far = (far_end_in_step & ~link_ev.far_oof) | link_ev.far_rsync_cmd;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         far_end_in_step <= '0;
      end else begin
         far_end_in_step <= next_far;
      end
   end

   always_comb begin
      sync_live = {far_end_in_step, link_ev.local_in_step};
   end

   // Enable registers.
   always_comb begin
      next_ctrl = ctrl;
      if (wr_cyc && reg_hit(wb_adr_i, IDX_SYNC_IE)) begin
         next_ctrl.sync_ie = wb_dat_i[7:0];
      end
      if (wr_cyc && reg_hit(wb_adr_i, IDX_SKEW_IE)) begin
         next_ctrl.skew_ie = RST_REG;
         next_ctrl.skew_ie[SKEW_ERR_BIT] = wb_dat_i[SKEW_ERR_BIT];
      end
      if (wr_cyc && reg_hit(wb_adr_i, IDX_OOF_IE)) begin
         next_ctrl.oof_ie = wb_dat_i[7:0];
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl <= {RST_REG, RST_REG, RST_REG};
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // Write-one-to-clear strobes for the latched registers.
   always_comb begin
      clr_sync = (wr_cyc && reg_hit(wb_adr_i, IDX_SYNC_LS)) ? wb_dat_i[7:0] : RST_REG;
      clr_oof = (wr_cyc && reg_hit(wb_adr_i, IDX_OOF_LS)) ? wb_dat_i[7:0] : RST_REG;
      clr_skew = (wr_cyc && reg_hit(wb_adr_i, IDX_SKEW_LS)) ? wb_dat_i[SKEW_ERR_BIT] : 1'b0;
   end

   ims_sticky #(
      .W(8)
   ) u_sync_ls (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .set_lvl(sync_live),
      .clr_w1c(clr_sync),
      .latched(sync_ls)
   );

   ims_sticky #(
      .W(8)
   ) u_oof_ls (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .set_lvl({link_ev.far_oof, link_ev.local_oof}),
      .clr_w1c(clr_oof),
      .latched(oof_ls)
   );

   ims_skew_meter #(
      .TICK(TICK)
   ) u_meter (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .frame_mark(link_ev.frame_mark),
      .participate(link_ev.participate),
      .skew(skew_val),
      .skew_valid(skew_valid)
   );

   always_comb begin
      skew_err_set = skew_valid && (skew_val > SKEW_LIMIT_CNT);
   end

   ims_sticky #(
      .W(1)
   ) u_skew_ls (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .set_lvl(skew_err_set),
      .clr_w1c(clr_skew),
      .latched(skew_ls)
   );

   // Interrupt summary.
   always_comb begin
      pend_sync = sync_ls & ctrl.sync_ie;
      pend_oof = oof_ls & ctrl.oof_ie;
      pend_skew = skew_ls[0] & ctrl.skew_ie[SKEW_ERR_BIT];
      pending = (|pend_sync) | (|pend_oof) | pend_skew;
      next_irq = pending;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         bonding_irq_summary <= 1'b0;
      end else begin
         bonding_irq_summary <= next_irq;
      end
   end

   // Bus answer: one wait state, read data registered with ack, unmapped reads zero.
   always_comb begin
      next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
      next_dat = RST_WORD;
      if (reg_hit(wb_adr_i, IDX_SYNC_LIVE)) begin
         next_dat[7:0] = sync_live;
      end
      if (reg_hit(wb_adr_i, IDX_SYNC_IE)) begin
         next_dat[7:0] = ctrl.sync_ie;
      end
      if (reg_hit(wb_adr_i, IDX_SYNC_LS)) begin
         next_dat[7:0] = sync_ls;
      end
      if (reg_hit(wb_adr_i, IDX_SKEW)) begin
         next_dat[7:0] = skew_val;
      end
      if (reg_hit(wb_adr_i, IDX_SKEW_IE)) begin
         next_dat[7:0] = ctrl.skew_ie;
      end
      if (reg_hit(wb_adr_i, IDX_SKEW_LS)) begin
         next_dat[SKEW_ERR_BIT] = skew_ls[0];
      end
      if (reg_hit(wb_adr_i, IDX_OOF_IE)) begin
         next_dat[7:0] = ctrl.oof_ie;
      end
      if (reg_hit(wb_adr_i, IDX_OOF_LS)) begin
         next_dat[7:0] = oof_ls;
      end
      if (!next_ack) begin
         next_dat = RST_WORD;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= RST_WORD;
      end else begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("Ack held for two cycles.");
   ack_resp_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("Request not answered in one cycle.");
   live_sync_a: assert property (link_ev.local_in_step[0] |=> sync_ls[LOCAL_LSB])
      else $error("Local sync not latched.");
   sync_ie_a: assert property ((wr_cyc && reg_hit(wb_adr_i, IDX_SYNC_IE))
      |=> ctrl.sync_ie == $past(wb_dat_i[7:0]))
      else $error("Sync enable write lost.");
   far_latch_a: assert property (far_end_in_step[3] |=> sync_ls[FAR_LSB + 3])
      else $error("Far sync not latched in bit 7.");
   skew_rd_a: assert property ((next_ack && reg_hit(wb_adr_i, IDX_SKEW))
      |=> wb_dat_o == {24'h000000, $past(skew_val)})
      else $error("Skew value read wrong.");
   skew_err_a: assert property ((skew_valid && skew_val > SKEW_LIMIT_CNT)
      |=> skew_ls[0])
      else $error("Skew error not latched.");
   skew_ok_a: assert property ((skew_valid && skew_val <= SKEW_LIMIT_CNT && !skew_ls[0])
      |=> !skew_ls[0])
      else $error("Skew error latched within limit.");
   skew_ie_a: assert property ((skew_ls[0] && ctrl.skew_ie[SKEW_ERR_BIT])
      |=> bonding_irq_summary)
      else $error("Enabled skew error gave no interrupt.");
   oof_ie_a: assert property ((oof_ls != RST_REG) && (pend_oof == RST_REG)
      && (pend_sync == RST_REG) && !pend_skew |=> !bonding_irq_summary)
      else $error("Masked frame loss raised the interrupt.");
   far_oof_a: assert property (link_ev.far_oof[3] |=> oof_ls[FAR_LSB + 3])
      else $error("Far frame loss not latched.");
   local_oof_a: assert property (link_ev.local_oof[0] |=> oof_ls[LOCAL_LSB])
      else $error("Local frame loss not latched.");
   far_step_a: assert property ((link_ev.far_rsync_cmd[0] ##1 !link_ev.far_oof[0])
      |=> far_end_in_step[0])
      else $error("Far sync lost without frame loss.");
   irq_sum_a: assert property (##1 bonding_irq_summary == $past(pending))
      else $error("Interrupt summary disagrees with pending events.");
   hold_a: assert property ((oof_ls[2] && clr_oof == RST_REG) |=> oof_ls[2])
      else $error("Latched frame loss dropped without a clear.");

   irq_rise_c: cover property (!bonding_irq_summary ##1 bonding_irq_summary);
   skew_err_c: cover property (!skew_ls[0] ##1 skew_ls[0]);
   oof_clear_c: cover property (oof_ls[0] ##1 !oof_ls[0]);
   far_step_c: cover property (link_ev.far_rsync_cmd[1] ##1 far_end_in_step[1]);

endmodule // ims_event_bank

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench;
   import ims_pkg::*;
   localparam int TK = 8;
   logic ref_clk;
   logic resetn;
   logic cyc;
   logic stb;
   logic we;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic ack;
   ims_link_ev_t ev;
   logic [NLINK-1:0] far_step;
   logic irq;
   logic [31:0] rd;
   int failures;
   int checked;

   ims_event_bank #(.TICK(TK)) dut (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .wb_cyc_i(cyc),
      .wb_stb_i(stb),
      .wb_we_i(we),
      .wb_adr_i(adr),
      .wb_sel_i(sel),
      .wb_dat_i(wdat),
      .wb_dat_o(rdat),
      .wb_ack_o(ack),
      .link_ev(ev),
      .far_end_in_step(far_step),
      .bonding_irq_summary(irq)
   );

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic end_of_test;
      if (failures == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One classic cycle; the request stands until ack is sampled high.
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h1;
      wdat <= {24'h000000, d};
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rd = rdat;
      if (n >= 50) begin
         failures++;
         $display("[FAIL] ack expected 1 seen %b", ack);
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, d);
   endtask

   task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 8'h00);
      check(name, exp, rd);
   endtask

   task automatic irq_is(input logic exp);
      check("bonding_irq_summary", {31'h0, exp}, {31'h0, irq});
   endtask

   // Marks link 0, then link 1 after k cycles, and reads the measured skew.
   task automatic skew(input int k, input logic [7:0] exp);
      @(posedge ref_clk);
      ev.frame_mark <= 4'h1;
      @(posedge ref_clk);
      ev.frame_mark <= 4'h0;
      repeat (k - 1) @(posedge ref_clk);
      ev.frame_mark <= 4'h2;
      @(posedge ref_clk);
      ev.frame_mark <= 4'h0;
      repeat (4) @(posedge ref_clk);
      rdc("link_skew_measure", 8'h6c, {24'h0, exp});
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      end_of_test();
   end

   initial begin
      failures = 0;
      checked = 0;
      resetn = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      wdat = 32'h0;
      ev = '0;
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      for (int i = 8'h60; i <= 8'h7c; i += 4) begin
         rdc("reset value", i[7:0], 32'h0);
      end
      rdc("unmapped", 8'h40, 32'h0);
      wr(8'h64, 8'ha5);
      rdc("sync_int_enable", 8'h64, 32'ha5);
      wr(8'h65, 8'h3c);
      rdc("misaligned write", 8'h64, 32'ha5);
      wr(8'h70, 8'hff);
      rdc("skew_error_int_enable", 8'h70, 32'h01);
      wr(8'h78, 8'h5a);
      rdc("frame_loss_int_enable", 8'h78, 32'h5a);
      wr(8'h6c, 8'h77);
      rdc("link_skew_measure", 8'h6c, 32'h0);
      wr(8'h64, 8'h01);
      wr(8'h70, 8'h00);
      wr(8'h78, 8'h04);
      // Local sync on a masked link, then on the enabled one.
      @(posedge ref_clk);
      ev.local_in_step <= 4'h2;
      repeat (3) @(posedge ref_clk);
      irq_is(1'b0);
      rdc("sync live", 8'h60, 32'h02);
      @(posedge ref_clk);
      ev.local_in_step <= 4'h3;
      repeat (3) @(posedge ref_clk);
      irq_is(1'b1);
      @(posedge ref_clk);
      ev.local_in_step <= 4'h0;
      repeat (2) @(posedge ref_clk);
      rdc("sync_latched_status", 8'h68, 32'h03);
      wr(8'h68, 8'h01);
      rdc("sync_latched_status", 8'h68, 32'h02);
      irq_is(1'b0);
      // Far end sync command, then far and local frame loss.
      @(posedge ref_clk);
      ev.far_rsync_cmd <= 4'h8;
      @(posedge ref_clk);
      ev.far_rsync_cmd <= 4'h0;
      repeat (2) @(posedge ref_clk);
      check("far_end_in_step", 32'h8, {28'h0, far_step});
      rdc("sync_latched_status", 8'h68, 32'h82);
      @(posedge ref_clk);
      ev.far_oof <= 4'h8;
      repeat (3) @(posedge ref_clk);
      check("far_end_in_step", 32'h0, {28'h0, far_step});
      irq_is(1'b0);
      rdc("frame_loss_latched", 8'h7c, 32'h80);
      @(posedge ref_clk);
      ev.local_oof <= 4'h4;
      repeat (3) @(posedge ref_clk);
      irq_is(1'b1);
      rdc("frame_loss_latched", 8'h7c, 32'h84);
      @(posedge ref_clk);
      ev.far_oof <= 4'h0;
      ev.local_oof <= 4'h0;
      wr(8'h7c, 8'hff);
      wr(8'h68, 8'hff);
      rdc("frame_loss_latched", 8'h7c, 32'h0);
      rdc("sync_latched_status", 8'h68, 32'h0);
      irq_is(1'b0);
      // Skew just at and just above the error limit, then saturation.
      wr(8'h70, 8'h01);
      @(posedge ref_clk);
      ev.participate <= 4'h3;
      skew(31 * TK + TK / 2, 8'd31);
      rdc("skew_error_latched", 8'h74, 32'h0);
      irq_is(1'b0);
      skew(32 * TK + TK / 2, 8'd32);
      rdc("skew_error_latched", 8'h74, 32'h1);
      irq_is(1'b1);
      wr(8'h74, 8'h01);
      rdc("skew_error_latched", 8'h74, 32'h0);
      skew(300 * TK, 8'hff);
      wr(8'h74, 8'h01);
      rdc("skew_error_latched", 8'h74, 32'h0);
      irq_is(1'b0);
      end_of_test();
   end
endmodule // testbench
